// file: core/cpc_top.sv
`timescale 1ns/1ps
`include "cpc_params.svh"
module cpc_top import cpc_pkg::*; #(
	parameter int STEP_CYC = `CPC_STEP_CYC,
	parameter int DET_CYC = `CPC_DET_CYC,
	parameter int SW_CYC = `CPC_SW_CYC,
	parameter int DAC_W = 8
) (
	// Clock, reset, enable
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clk_en,
	// Comparator inputs (asynchronous)
	input wire logic boot_supply_low,
	input wire logic error_amp_above_ramp,
	input wire logic sense_above_sync_trip,
	input wire logic sense_above_sync_return,
	input wire logic main_supply_above_5v,
	input wire logic main_supply_above_supply_undervoltage_lockout,
	input wire logic adapter_detect_above_0v6,
	input wire logic adapter_detect_above_2v4,
	input wire logic adapter_detect_above_3v1,
	input wire logic adapter_above_pack,
	input wire logic input_sense_high_above_3v,
	input wire logic pack_above_104,
	input wire logic pack_above_102,
	input wire logic charge_above_145,
	input wire logic die_above_155,
	input wire logic die_above_135,
	input wire logic temp_qualified,
	input wire logic charge_enable_n,
	// Gate drives and analog controls
	output logic high_side_gate,
	output logic low_side_gate,
	output logic input_switch_gate,
	output logic pack_switch_gate,
	output logic input_current_monitor_en,
	output logic gate_drive_regulator_en,
	output logic [DAC_W-1:0] charge_target,
	output logic sync_mode,
	// AXI4-Lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	localparam int NIN = 17;
	localparam int SW_W = 16;
	localparam int ST_W = 25;
	localparam int DT_W = 25;

	// ---------------------------------------------------------------
	// Input synchronisers
	// ---------------------------------------------------------------
	logic [NIN-1:0] raw;
	logic [NIN-1:0] sync1_ff;
	logic [NIN-1:0] sync2_ff;
	assign raw = {boot_supply_low, error_amp_above_ramp, sense_above_sync_trip,
		sense_above_sync_return, main_supply_above_5v, main_supply_above_supply_undervoltage_lockout,
		adapter_detect_above_0v6, adapter_detect_above_2v4, adapter_detect_above_3v1,
		adapter_above_pack, input_sense_high_above_3v, pack_above_104, pack_above_102,
		charge_above_145, die_above_155, die_above_135, temp_qualified};
	genvar gi;
	generate
		for (gi = 0; gi < NIN; gi++) begin : g_sync
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					sync1_ff[gi] <= 1'b0;
					sync2_ff[gi] <= 1'b0;
				end else if (clk_en) begin
					sync1_ff[gi] <= raw[gi];
					sync2_ff[gi] <= sync1_ff[gi];
				end
			end
		end
	endgenerate
	logic boot_low, ea_hi, trip_hi, ret_hi, sup5, supuv, ad06, ad24, ad31;
	logic ad_gt_pk, ins3, pk104, pk102, oc145, t155, t135, tq;
	assign {boot_low, ea_hi, trip_hi, ret_hi, sup5, supuv, ad06, ad24, ad31,
		ad_gt_pk, ins3, pk104, pk102, oc145, t155, t135, tq} = sync2_ff;
	logic en_n_s1_ff, en_n_s2_ff;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			en_n_s1_ff <= 1'b1;
			en_n_s2_ff <= 1'b1;
		end else if (clk_en) begin
			en_n_s1_ff <= charge_enable_n;
			en_n_s2_ff <= en_n_s1_ff;
		end
	end

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	logic [31:0] ctrl_ff;
	logic [DAC_W-1:0] prog_current;
	logic sw_inhibit;
	assign prog_current = ctrl_ff[DAC_W-1:0];
	assign sw_inhibit = ctrl_ff[31];

	// ---------------------------------------------------------------
	// Adapter qualification and protections
	// ---------------------------------------------------------------
	logic [DT_W-1:0] det_cnt_ff;
	logic det_done_ff;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			det_cnt_ff <= '0;
			det_done_ff <= 1'b0;
		end else if (clk_en) begin
			if (!ad24 || !supuv) begin
				det_cnt_ff <= '0;
				det_done_ff <= 1'b0;
			end else if (det_cnt_ff == DT_W'(DET_CYC - 1)) begin
				det_done_ff <= 1'b1;
			end else begin
				det_cnt_ff <= det_cnt_ff + DT_W'(1);
			end
		end
	end

	logic ovp_bat_ff, thermal_shutdown_ff, sync_ff, bbm_latch_ff;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ovp_bat_ff <= 1'b0;
			thermal_shutdown_ff <= 1'b0;
		end else if (clk_en) begin
			if (pk104)
				ovp_bat_ff <= 1'b1;
			else if (!pk102)
				ovp_bat_ff <= 1'b0;
			if (t155)
				thermal_shutdown_ff <= 1'b1;
			else if (!t135)
				thermal_shutdown_ff <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			sync_ff <= 1'b0;
		else if (clk_en) begin
			if (!trip_hi)
				sync_ff <= 1'b0;
			else if (ret_hi)
				sync_ff <= 1'b1;
		end
	end
	assign sync_mode = sync_ff;

	logic chg_ok;
	assign chg_ok = !en_n_s2_ff && supuv && sup5 && ad24 && ad_gt_pk && det_done_ff
		&& !ad31 && !thermal_shutdown_ff && tq && !sw_inhibit;

	// Selector: latch set once adapter path connected; cleared by low sense or lockout
	always_ff @(posedge aclk) begin
		if (!aresetn)
			bbm_latch_ff <= 1'b0;
		else if (clk_en) begin
			if (!ins3 || !supuv)
				bbm_latch_ff <= 1'b0;
			else if (det_done_ff && !ad31)
				bbm_latch_ff <= 1'b1;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			input_switch_gate <= 1'b0;
			pack_switch_gate <= 1'b0;
			input_current_monitor_en <= 1'b0;
			gate_drive_regulator_en <= 1'b0;
		end else if (clk_en) begin
			input_switch_gate <= sup5 && det_done_ff && !ad31;
			pack_switch_gate <= sup5 && ins3 && (ad31 || !bbm_latch_ff);
			input_current_monitor_en <= sup5 && ad06;
			gate_drive_regulator_en <= sup5 && ad06 && !en_n_s2_ff;
		end
	end

	// ---------------------------------------------------------------
	// Soft start
	// ---------------------------------------------------------------
	logic [ST_W-1:0] step_cnt_ff;
	logic [3:0] step_ff;
	logic chg_on_ff;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			step_cnt_ff <= '0;
			step_ff <= 4'h0;
			chg_on_ff <= 1'b0;
			charge_target <= '0;
		end else if (clk_en) begin
			chg_on_ff <= chg_ok;
			if (!chg_ok) begin
				step_cnt_ff <= '0;
				step_ff <= 4'h0;
				charge_target <= '0;
			end else if (!chg_on_ff) begin
				step_ff <= 4'h1;
				step_cnt_ff <= '0;
			end else begin
				charge_target <= DAC_W'((32'(prog_current) * 32'(step_ff)) / `CPC_SS_STEPS);
				if (step_ff < 4'(`CPC_SS_STEPS)) begin
					if (step_cnt_ff == ST_W'(STEP_CYC - 1)) begin
						step_cnt_ff <= '0;
						step_ff <= step_ff + 4'h1;
					end else
						step_cnt_ff <= step_cnt_ff + ST_W'(1);
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// PWM sequencer
	// ---------------------------------------------------------------
	logic [SW_W-1:0] per_cnt_ff;
	logic [SW_W-1:0] ph_cnt_ff;
	logic [1:0] boot_cyc_ff;
	logic refresh_ff;
	cpc_phase_t ph_ff;
	logic cyc_start, hs_allow, refresh_set;
	assign cyc_start = (per_cnt_ff == SW_W'(SW_CYC - 1));
	// Refresh and shutdown take effect on the edge that sets their flags, not one later
	assign refresh_set = cyc_start && boot_low && (boot_cyc_ff == 2'(`CPC_BOOT_CYCLES));
	assign hs_allow = chg_on_ff && !ovp_bat_ff && !pk104 && !oc145 && !thermal_shutdown_ff && !t155
		&& !refresh_ff && !refresh_set;

	always_ff @(posedge aclk) begin
		if (!aresetn)
			per_cnt_ff <= '0;
		else if (clk_en)
			per_cnt_ff <= cyc_start ? '0 : per_cnt_ff + SW_W'(1);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			boot_cyc_ff <= 2'h0;
			refresh_ff <= 1'b0;
		end else if (clk_en && cyc_start) begin
			if (!boot_low) begin
				boot_cyc_ff <= 2'h0;
				refresh_ff <= 1'b0;
			end else if (boot_cyc_ff == 2'(`CPC_BOOT_CYCLES)) begin
				refresh_ff <= 1'b1;
			end else
				boot_cyc_ff <= boot_cyc_ff + 2'h1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ph_ff <= PH_IDLE;
			ph_cnt_ff <= '0;
		end else if (clk_en) begin
			ph_cnt_ff <= ph_cnt_ff + SW_W'(1);
			if (cyc_start) begin
				ph_cnt_ff <= '0;
				if (!chg_on_ff || thermal_shutdown_ff)
					ph_ff <= PH_IDLE;
				else if (hs_allow && ea_hi)
					ph_ff <= PH_HIGH;
				else
					ph_ff <= PH_DEAD1;
			end else begin
				case (ph_ff)
					PH_HIGH: begin
						if (!ea_hi || !hs_allow || pk104) begin
							ph_ff <= PH_DEAD1;
							ph_cnt_ff <= '0;
						end
					end
					PH_DEAD1: begin
						if (ph_cnt_ff >= SW_W'(`CPC_DEAD_CYC - 1)) begin
							ph_ff <= PH_LOW;
							ph_cnt_ff <= '0;
						end
					end
					PH_LOW: begin
						if (!sync_ff || refresh_ff || boot_low || ovp_bat_ff) begin
							if (ph_cnt_ff >= SW_W'(`CPC_LPULSE_CYC - 1))
								ph_ff <= PH_REST;
						end else if (per_cnt_ff >= SW_W'(SW_CYC - 1 - `CPC_DEAD_CYC))
							ph_ff <= PH_DEAD2;
					end
					PH_DEAD2: ph_ff <= PH_DEAD2;
					PH_REST: ph_ff <= PH_REST;
					default: ph_ff <= PH_IDLE;
				endcase
			end
		end
	end
	// Low-side pulse after each high-side phase that ends within its period, so the boot cap refills
	assign high_side_gate = (ph_ff == PH_HIGH);
	assign low_side_gate = (ph_ff == PH_LOW);

	// ---------------------------------------------------------------
	// AXI4-Lite slave
	// ---------------------------------------------------------------
	logic [7:0] aw_ff;
	logic aw_got_ff, w_got_ff;
	logic [31:0] wd_ff;
	logic [3:0] ws_ff;
	assign s_axi_awready = !aw_got_ff && !s_axi_bvalid;
	assign s_axi_wready = !w_got_ff && !s_axi_bvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_ff <= 1'b0;
			w_got_ff <= 1'b0;
			aw_ff <= 8'h00;
			wd_ff <= 32'h0000_0000;
			ws_ff <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
			ctrl_ff <= `CPC_CTRL_RST;
		end else if (clk_en) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_ff <= s_axi_awaddr;
				aw_got_ff <= 1'b1;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wd_ff <= s_axi_wdata;
				ws_ff <= s_axi_wstrb;
				w_got_ff <= 1'b1;
			end
			if (aw_got_ff && w_got_ff) begin
				aw_got_ff <= 1'b0;
				w_got_ff <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if (32'(aw_ff) == `CPC_OFF_CTRL) begin
					for (int b = 0; b < 4; b++)
						if (ws_ff[b])
							ctrl_ff[b*8 +: 8] <= wd_ff[b*8 +: 8];
					s_axi_bresp <= RESP_OKAY;
				end else if (32'(aw_ff) == `CPC_OFF_STAT || 32'(aw_ff) == `CPC_OFF_CHG)
					s_axi_bresp <= RESP_OKAY;
				else
					s_axi_bresp <= RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	logic [31:0] stat_word;
	assign stat_word = {20'h00000, sync_ff, refresh_ff, thermal_shutdown_ff, ovp_bat_ff, oc145, ad31,
		det_done_ff, chg_on_ff, step_ff};
	assign s_axi_arready = !s_axi_rvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'b00;
		end else if (clk_en) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= RESP_OKAY;
				if (32'(s_axi_araddr) == `CPC_OFF_CTRL)
					s_axi_rdata <= ctrl_ff;
				else if (32'(s_axi_araddr) == `CPC_OFF_STAT)
					s_axi_rdata <= stat_word;
				else if (32'(s_axi_araddr) == `CPC_OFF_CHG)
					s_axi_rdata <= 32'(charge_target);
				else begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= RESP_SLVERR;
				end
			end else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	property p_no_overlap;
		@(posedge aclk) disable iff (!aresetn) !(high_side_gate && low_side_gate);
	endproperty
	a_no_overlap: assert property (p_no_overlap) else $error("both gates on");
	property p_dead_gap;
		@(posedge aclk) disable iff (!aresetn)
		clk_en && $fell(high_side_gate) |-> !low_side_gate;
	endproperty
	a_dead_gap: assert property (p_dead_gap) else $error("no dead time");
	property p_ovp_hs;
		@(posedge aclk) disable iff (!aresetn) ovp_bat_ff |-> !high_side_gate;
	endproperty
	a_ovp_hs: assert property (p_ovp_hs) else $error("high side in overvoltage");
	property p_oc_hs;
		@(posedge aclk) disable iff (!aresetn) clk_en && oc145 |=> !high_side_gate;
	endproperty
	a_oc_hs: assert property (p_oc_hs) else $error("high side in overcurrent");
	property p_thermal_shutdown;
		@(posedge aclk) disable iff (!aresetn) thermal_shutdown_ff |-> !high_side_gate;
	endproperty
	a_thermal_shutdown: assert property (p_thermal_shutdown) else $error("switching in shutdown");
	property p_input_overvoltage;
		@(posedge aclk) disable iff (!aresetn)
		clk_en && ad31 |=> !input_switch_gate && !chg_on_ff;
	endproperty
	a_input_overvoltage: assert property (p_input_overvoltage) else $error("overvoltage not handled");
	property p_mon;
		@(posedge aclk) disable iff (!aresetn)
		clk_en && !sup5 |=> !input_current_monitor_en && !gate_drive_regulator_en;
	endproperty
	a_mon: assert property (p_mon) else $error("bias active at low supply");
	property p_pack_off;
		@(posedge aclk) disable iff (!aresetn) clk_en && !ins3 |=> !pack_switch_gate;
	endproperty
	a_pack_off: assert property (p_pack_off) else $error("pack switch on");
	property p_refresh;
		@(posedge aclk) disable iff (!aresetn) refresh_ff |-> !high_side_gate;
	endproperty
	a_refresh: assert property (p_refresh) else $error("high side in refresh");
	property p_step;
		@(posedge aclk) disable iff (!aresetn) step_ff <= 4'(`CPC_SS_STEPS);
	endproperty
	a_step: assert property (p_step) else $error("step overflow");
	c_hs: cover property (@(posedge aclk) $rose(high_side_gate));
	c_ss_done: cover property (@(posedge aclk) step_ff == 4'(`CPC_SS_STEPS));
	c_sync: cover property (@(posedge aclk) sync_ff && low_side_gate);
	c_refresh: cover property (@(posedge aclk) $rose(refresh_ff));
endmodule : cpc_top

// file: core/cpc_params.svh
// Notes on behaviour
// - Each charge enable ramps the current target upward in 8 equal steps.
// - Each soft-start step lasts about 1 ms, full ramp about 7 ms.
// - Switching period is fixed at 300 kHz under all conditions.
// - Error level below ramp gives 0% duty; above ramp allows 100% duty.
// - Boot supply low over 3 cycles: high side off, low side recharges.
// - After refresh, return to full duty; refresh again only when low again.
// - Non-synchronous below the sync current threshold, synchronous otherwise.
// - Synchronous: low side on when high side off (80 ns pulse only in pack overvoltage, boot low or refresh), dead gaps of one 40 ns clock (30 ns rounded up).
// - Non-synchronous: after dead time, low side pulses about 80 ns only.
// - Boot supply low: low side limited to the 80 ns recharge pulse; no high side once refresh is set.
// - Sync threshold trips at 13 mV falling, 8 mV hysteresis rising.
// - Input current monitor grounded unless supply above 5 V and detect above 0.6 V.
// - Detect above 3.1 V: charge off, input switch off, pack switch on.
// - Input overvoltage is not latched; recovery when detect falls below 3.1 V.
// - Supply under 5 V keeps regulator, reference and selector bias off.
// - Selector protection latch clears on input sense low or supply lockout.
// - Pack switch forced off while input sense node is under 3 V.
// - High side stops within one cycle when pack voltage exceeds 104%.
// - High side stays off after overvoltage until pack voltage under 102%.
// - High side off while current exceeds 145%; resumes automatically below.
// - Shutdown above 155 C, stays off until below 135 C.
// - Charge enabled only with enable low and all qualification conditions true.
`ifndef CPC_PARAMS_SVH
`define CPC_PARAMS_SVH

`define CPC_CLK_HZ 25000000
`define CPC_SW_HZ 300000
`define CPC_SW_CYC (`CPC_CLK_HZ / `CPC_SW_HZ)
`define CPC_DEAD_NS 30
`define CPC_DEAD_CYC (((`CPC_DEAD_NS * 25) + 999) / 1000)
`define CPC_LPULSE_NS 80
`define CPC_LPULSE_CYC ((`CPC_LPULSE_NS * 25) / 1000)
`define CPC_STEP_US 1000
`define CPC_STEP_CYC (`CPC_STEP_US * 25)
`define CPC_SS_STEPS 8
`define CPC_BOOT_CYCLES 3
`define CPC_DET_MS 700
`define CPC_DET_CYC (`CPC_DET_MS * 25000)

`define CPC_OFF_CTRL 32'h0000_0000
`define CPC_OFF_STAT 32'h0000_0004
`define CPC_OFF_CHG 32'h0000_0008
`define CPC_CTRL_RST 32'h0000_0000

`endif

// file: core/cpc_pkg.sv
package cpc_pkg;
	typedef enum logic [2:0] {PH_IDLE, PH_HIGH, PH_DEAD1, PH_LOW, PH_DEAD2, PH_REST} cpc_phase_t;
	typedef enum logic [1:0] {RESP_OKAY = 2'b00, RESP_SLVERR = 2'b10} cpc_resp_t;
endpackage : cpc_pkg

// file: dv/cpc_drv_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Bootstrap capacitor behind the gate drivers
// ----------------------------------------
module cpc_drv_model (
	// Clock
	input wire logic aclk,
	// Gate drives from the controller
	input wire logic high_side_gate,
	input wire logic low_side_gate,
	// Scenario control: heavy leakage
	input wire logic leak_fast,
	// Comparator back to the controller
	output logic boot_supply_low
);
	int charge_ff = 0;
	int nxt_drop;

	// Drains only while the high side conducts; any low side pulse refills it
	assign nxt_drop = leak_fast ? 40 : 1;
	always_ff @(posedge aclk) begin
		if (low_side_gate)
			charge_ff <= 400;
		else if (high_side_gate)
			charge_ff <= (charge_ff > nxt_drop) ? charge_ff - nxt_drop : 0;
	end
	assign boot_supply_low = (charge_ff == 0);
endmodule : cpc_drv_model

// file: dv/charger_pwm_control_and_protection_tb_top.sv
`timescale 1ns/1ps
module charger_pwm_control_and_protection_tb_top;
	import cpc_pkg::*;
	localparam int STEP = 20;
	localparam int DET = 10;
	localparam int SW = 83;
	typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} cpc_rd_t;
	logic aclk = 1'b0, aresetn = 1'b0, leak_fast = 1'b0, boot_supply_low;
	logic error_amp_above_ramp = 1'b0, sense_above_sync_trip = 1'b0;
	logic sense_above_sync_return = 1'b0, main_supply_above_5v = 1'b0;
	logic main_supply_above_supply_undervoltage_lockout = 1'b0, adapter_detect_above_0v6 = 1'b0;
	logic adapter_detect_above_2v4 = 1'b0, adapter_detect_above_3v1 = 1'b0;
	logic adapter_above_pack = 1'b0, input_sense_high_above_3v = 1'b0;
	logic pack_above_104 = 1'b0, pack_above_102 = 1'b0, charge_above_145 = 1'b0;
	logic die_above_155 = 1'b0, die_above_135 = 1'b0, temp_qualified = 1'b0;
	logic charge_enable_n = 1'b1;
	logic high_side_gate, low_side_gate, input_switch_gate, pack_switch_gate;
	logic input_current_monitor_en, gate_drive_regulator_en, sync_mode;
	logic [7:0] charge_target;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	int failures = 0;
	int comparisons = 0;
	logic [7:0] tq[$];
	logic [1:0] bq[$];
	cpc_rd_t rq[$];
	cpc_rd_t e;
	logic [31:0] rnd = 32'hCBF2_6871;
	logic track = 1'b0, hs_q = 1'b0, per_ok = 1'b0;
	logic [7:0] ct_q = 8'h00;
	int lw = 0, gap = 0, sgap = 0;

	cpc_top #(.STEP_CYC(STEP), .DET_CYC(DET), .SW_CYC(SW), .DAC_W(8)) cpc_top_i (
		.aclk, .aresetn, .clk_en(1'b1), .boot_supply_low, .error_amp_above_ramp,
		.sense_above_sync_trip, .sense_above_sync_return, .main_supply_above_5v,
		.main_supply_above_supply_undervoltage_lockout, .adapter_detect_above_0v6, .adapter_detect_above_2v4,
		.adapter_detect_above_3v1, .adapter_above_pack, .input_sense_high_above_3v,
		.pack_above_104, .pack_above_102, .charge_above_145, .die_above_155,
		.die_above_135, .temp_qualified, .charge_enable_n, .high_side_gate,
		.low_side_gate, .input_switch_gate, .pack_switch_gate, .input_current_monitor_en,
		.gate_drive_regulator_en, .charge_target, .sync_mode, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready
	);
	cpc_drv_model cpc_drv_model_i (.aclk, .high_side_gate, .low_side_gate, .leak_fast,
		.boot_supply_low);

	initial begin
		forever #20 aclk = ~aclk;
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	task automatic final_report;
		if (failures == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : final_report

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("mismatch %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic hang(input string what);
		chk(0, 1, what);
		final_report();
	endtask : hang

	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask : cyc

	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
			input logic [1:0] r);
		logic aw, w, done;
		done = 1'b0;
		bq.push_back(r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (int n = 0; n < 100 && !done; n++) begin
			@(negedge aclk);
			aw = s_axi_awvalid && s_axi_awready;
			w = s_axi_wvalid && s_axi_wready;
			done = s_axi_bvalid;
			@(posedge aclk);
			if (aw)
				s_axi_awvalid <= 1'b0;
			if (w)
				s_axi_wvalid <= 1'b0;
			if (done)
				s_axi_bready <= 1'b0;
		end
		if (!done)
			hang("write hang");
	endtask : axw

	task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
			input logic [1:0] r);
		logic ar, done;
		done = 1'b0;
		rq.push_back('{d, m, r});
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (int n = 0; n < 100 && !done; n++) begin
			@(negedge aclk);
			ar = s_axi_arvalid && s_axi_arready;
			done = s_axi_rvalid;
			@(posedge aclk);
			if (ar)
				s_axi_arvalid <= 1'b0;
			if (done)
				s_axi_rready <= 1'b0;
		end
		if (!done)
			hang("read hang");
	endtask : axr

	task automatic ramp;
		for (int k = 1; k <= 8; k++)
			tq.push_back(8'(k * 8));
		for (int n = 0; n < 5000 && tq.size() != 0; n++)
			@(negedge aclk);
		if (tq.size() != 0)
			hang("ramp hang");
	endtask : ramp

	task automatic set_fault(input int k, input logic hi, input logic lo);
		@(posedge aclk);
		case (k)
			0: begin
				pack_above_104 <= hi;
				pack_above_102 <= lo;
			end
			1: charge_above_145 <= hi;
			2: begin
				die_above_155 <= hi;
				die_above_135 <= lo;
			end
			default: adapter_detect_above_3v1 <= hi;
		endcase
	endtask : set_fault

	task automatic high_count(input int n, output int c);
		c = 0;
		repeat (n) begin
			@(negedge aclk);
			c += int'(high_side_gate);
		end
	endtask : high_count

	// ----------------------------------------
	// Output watcher
	// ----------------------------------------
	always @(negedge aclk) begin
		if (aresetn) begin
			if (high_side_gate && low_side_gate)
				chk(1, 0, "gates overlap");
			lw = (low_side_gate && !sync_mode) ? lw + 1 : 0;
			if (lw > 2)
				chk(lw, 2, "low pulse long");
			gap++;
			if (high_side_gate && !hs_q) begin
				if (per_ok)
					chk(gap % SW, 0, "period");
				per_ok = 1'b1;
				gap = 0;
			end
			hs_q = high_side_gate;
			sgap++;
			if (charge_target !== ct_q) begin
				if (track && charge_target != 8'h00 && tq.size() != 0)
					chk(charge_target, tq.pop_front(), "ramp step");
				if (track && ct_q != 8'h00 && charge_target > ct_q)
					chk(sgap >= STEP - 2 && sgap <= STEP + 2, 1, "step time");
				sgap = 0;
				ct_q = charge_target;
			end
			if (s_axi_rvalid && s_axi_rready) begin
				e = rq.pop_front();
				chk(s_axi_rdata & e.m, e.d, "rdata");
				chk(s_axi_rresp, e.r, "rresp");
			end
			if (s_axi_bvalid && s_axi_bready)
				chk(s_axi_bresp, bq.pop_front(), "bresp");
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		int c, lr, hr;
		logic lo_q, hi_q;
		logic [2:0] sync_tab[6];
		sync_tab = '{3'b111, 3'b101, 3'b000, 3'b100, 3'b111, 3'b000};
		cyc(4);
		aresetn <= 1'b1;
		axr(8'h00, 32'h0, 32'hFFFF_FFFF, RESP_OKAY);
		axw(8'h00, 32'hFFFF_FF12, 4'h1, RESP_OKAY);
		axr(8'h00, 32'h12, 32'h8000_00FF, RESP_OKAY);
		axw(8'h00, 32'h40, 4'hF, RESP_OKAY);
		axw(8'h10, 32'h5, 4'hF, RESP_SLVERR);
		axr(8'h0C, 32'h0, 32'hFFFF_FFFF, RESP_SLVERR);
		@(posedge aclk);
		{main_supply_above_5v, main_supply_above_supply_undervoltage_lockout, adapter_detect_above_0v6} <= 3'b111;
		{adapter_detect_above_2v4, adapter_above_pack, input_sense_high_above_3v} <= 3'b111;
		temp_qualified <= 1'b1;
		charge_enable_n <= 1'b0;
		track <= 1'b1;
		ramp();
		axr(8'h04, 32'h10, 32'h10, RESP_OKAY);
		chk({input_current_monitor_en, gate_drive_regulator_en}, 2'b11, "bias on");
		charge_enable_n <= 1'b1;
		cyc(10);
		charge_enable_n <= 1'b0;
		ramp();
		foreach (sync_tab[i]) begin
			@(posedge aclk);
			{sense_above_sync_trip, sense_above_sync_return} <= sync_tab[i][2:1];
			cyc(6);
			@(negedge aclk);
			chk(sync_mode, sync_tab[i][0], "mode");
			for (int j = 0; j < 400; j++) begin
				@(posedge aclk);
				rnd = lfsr(rnd);
				error_amp_above_ramp <= rnd[0];
			end
			chk(sync_mode, sync_tab[i][0], "mode held");
		end
		@(posedge aclk);
		leak_fast <= 1'b1;
		error_amp_above_ramp <= 1'b1;
		{lr, hr, lo_q, hi_q} = '0;
		repeat (10 * SW) begin
			@(negedge aclk);
			lr += int'(low_side_gate && !lo_q);
			hr += int'(high_side_gate && !hi_q && lr > 0);
			{lo_q, hi_q} = {low_side_gate, high_side_gate};
		end
		chk(lr > 0, 1, "refresh");
		chk(hr > 0, 1, "duty back");
		leak_fast <= 1'b0;
		for (int k = 0; k < 4; k++) begin
			set_fault(k, 1'b1, 1'b1);
			cyc(SW + 6);
			high_count(2 * SW, c);
			chk(c, 0, "fault off");
			if (k == 3) begin
				chk({input_switch_gate, pack_switch_gate}, 2'b01, "ov switches");
				axr(8'h04, 32'h40, 32'h50, RESP_OKAY);
			end
			set_fault(k, 1'b0, 1'b1);
			cyc(6);
			high_count(SW, c);
			if (k == 0 || k == 2)
				chk(c, 0, "hysteresis");
			set_fault(k, 1'b0, 1'b0);
			for (c = 0; c < 3000 && high_side_gate !== 1'b1; c++)
				@(negedge aclk);
			if (c == 3000)
				hang("no resume");
		end
		@(posedge aclk);
		input_sense_high_above_3v <= 1'b0;
		cyc(6);
		@(negedge aclk);
		chk(pack_switch_gate, 1'b0, "pack forced off");
		@(posedge aclk);
		main_supply_above_5v <= 1'b0;
		cyc(6);
		@(negedge aclk);
		chk({input_current_monitor_en, gate_drive_regulator_en}, 2'b00, "bias off");
		final_report();
	end
endmodule : charger_pwm_control_and_protection_tb_top
